//--- design/pws_consts.vh
// Register offsets, field positions and reset values for the shutdown and clock-select block
`ifndef PWS_CONSTS_VH
`define PWS_CONSTS_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define PWS_ADDR_ENABLE     8'h00
`define PWS_ADDR_CLKSEL     8'h02
`define PWS_ADDR_PRESCALE   8'h03
`define PWS_ADDR_CTRL       8'h05
`define PWS_ADDR_SCALE_A    8'h08
`define PWS_ADDR_SCALE_B    8'h09
`define PWS_ADDR_SHUTDOWN   8'h24
`define PWS_ADDR_BITS       8

// ****************************************************************
// Shutdown register fields
// ****************************************************************
`define PWS_SD_FLAG         7
`define PWS_SD_IRQ_EN       6
`define PWS_SD_RESTART      5
`define PWS_SD_LEVEL        4
`define PWS_SD_PIN          2
`define PWS_SD_ACT_LVL      1
`define PWS_SD_ENABLE       0

// ****************************************************************
// Other fields and constants
// ****************************************************************
`define PWS_CTRL_FREEZE     2
`define PWS_PRE_A_LSB       0
`define PWS_PRE_B_LSB       4
`define PWS_PRE_W           3
`define PWS_ZERO8           8'h00
`define PWS_ONE8            8'h01
`define PWS_ZERO7           7'h00
`define PWS_RESET8          8'h00

`endif

//--- design/pws_top.v
// Emergency shutdown and channel clock generation for an eight-channel modulator
`timescale 1ns/1ps
`include "pws_consts.vh"

// Function
// - Flag sets on every passive-to-active or active-to-passive change while emergency enable is set.
// - Writing one clears the flag; writing zero leaves it.
// - Interrupt request asserts while flag, interrupt enable and emergency enable are all set.
// - Restart trigger resumes only with input deasserted, after counter zero; reads zero.
// - Clearing emergency enable releases outputs only after counters pass zero.
// - Active input immediately forces enabled outputs to the chosen level.
// - Status bit two reads the synchronised pin level.
// - Active level select: zero low, one high.
// - Emergency enable makes pin an input and arms shutdown.
// - Freeze gate with freeze active stops the prescaler clock.
// - Prescaler stops while all eight channel enables are zero.
// - Clocks A and B divide bus clock by 1 to 128 independently.
// - Scaled clock uses 8-bit reloading down counter then divide by two.
// - Scale value zero counts as 256, giving division by 512.
// - Writing a scale register reloads its down counter at once.
// - Channels 0,1,4,5 use A or SA; channels 2,3,6,7 use B or SB.
module pws_top (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Wishbone slave
    input  wire       wb_cyc_i,
    input  wire       wb_stb_i,
    input  wire       wb_we_i,
    input  wire [7:0] wb_adr_i,
    input  wire [7:0] wb_dat_i,
    input  wire       wb_sel_i,
    output reg  [7:0] wb_dat_o,
    output reg        wb_ack_o,
    // System
    input  wire       freeze_i,
    input  wire [7:0] counter_zero_i,
    output reg        irq_o,
    // Channel seven pin
    input  wire       fault_pin_i,
    output reg        fault_pin_oe_n_o,
    // Channel side
    output reg  [7:0] channel_enable_o,
    output reg  [7:0] channel_clk_en_o,
    output reg        force_active_o,
    output reg        forced_output_level_o
);

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    reg  [7:0] channel_enable;
    reg  [7:0] clock_select_reg;
    reg  [7:0] prescale_select_reg;
    reg        freeze_clock_gate;
    reg  [7:0] scale_value_a;
    reg  [7:0] scale_value_b;
    reg        shutdown_change_flag;
    reg        shutdown_irq_enable;
    reg        forced_output_level;
    reg        fault_active_level;
    reg        emergency_enable;
    reg        pin_meta;
    reg        pin_sync;
    reg        fault_prev;
    reg        shut_hold;
    reg  [6:0] prescale_cnt;
    reg  [7:0] down_a;
    reg  [7:0] down_b;
    reg        div2_a;
    reg        div2_b;

    wire       wr_stb;
    wire       rd_stb;
    wire       fault_active;
    wire       pre_run;
    wire [6:0] next_prescale_cnt;
    wire       clk_a_en;
    wire       clk_b_en;
    wire       pulse_a;
    wire       pulse_b;
    wire       sa_en;
    wire       sb_en;
    wire       wr_scale_a;
    wire       wr_scale_b;
    wire       wr_shutdown;
    reg  [7:0] next_rd;
    reg  [7:0] next_clk_en;
    integer    ch;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function prescale_tick;
        input [6:0] cnt;
        input [2:0] sel;
        reg   [7:0] mask;
        begin
            mask          = (`PWS_ONE8 << sel) - `PWS_ONE8;
            prescale_tick = ((cnt & mask[6:0]) == mask[6:0]);
        end
    endfunction

    function [7:0] reload_value;
        input [7:0] scale;
        begin
            reload_value = scale;
        end
    endfunction

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    assign wr_stb      = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i & ~wb_ack_o;
    assign rd_stb      = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
    assign wr_scale_a  = wr_stb & (wb_adr_i == `PWS_ADDR_SCALE_A);
    assign wr_scale_b  = wr_stb & (wb_adr_i == `PWS_ADDR_SCALE_B);
    assign wr_shutdown = wr_stb & (wb_adr_i == `PWS_ADDR_SHUTDOWN);

    always @* begin
        if (wb_adr_i == `PWS_ADDR_ENABLE) begin
            next_rd = channel_enable;
        end else if (wb_adr_i == `PWS_ADDR_CLKSEL) begin
            next_rd = clock_select_reg;
        end else if (wb_adr_i == `PWS_ADDR_PRESCALE) begin
            next_rd = prescale_select_reg;
        end else if (wb_adr_i == `PWS_ADDR_CTRL) begin
            next_rd = `PWS_ZERO8;
            next_rd[`PWS_CTRL_FREEZE] = freeze_clock_gate;
        end else if (wb_adr_i == `PWS_ADDR_SCALE_A) begin
            next_rd = scale_value_a;
        end else if (wb_adr_i == `PWS_ADDR_SCALE_B) begin
            next_rd = scale_value_b;
        end else if (wb_adr_i == `PWS_ADDR_SHUTDOWN) begin
            next_rd = `PWS_ZERO8;
            next_rd[`PWS_SD_FLAG]    = shutdown_change_flag;
            next_rd[`PWS_SD_IRQ_EN]  = shutdown_irq_enable;
            next_rd[`PWS_SD_LEVEL]   = forced_output_level;
            next_rd[`PWS_SD_PIN]     = pin_sync;
            next_rd[`PWS_SD_ACT_LVL] = fault_active_level;
            next_rd[`PWS_SD_ENABLE]  = emergency_enable;
        end else begin
            next_rd = `PWS_ZERO8;
        end
    end

    // ****************************************************************
    // Shutdown logic
    // ****************************************************************
    assign fault_active = emergency_enable & (pin_sync == fault_active_level);

    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta   <= 1'b0;
            pin_sync   <= 1'b0;
            fault_prev <= 1'b0;
        end else begin
            pin_meta   <= fault_pin_i;
            pin_sync   <= pin_meta;
            fault_prev <= fault_active;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            shutdown_change_flag <= 1'b0;
            shutdown_irq_enable  <= 1'b0;
            forced_output_level  <= 1'b0;
            fault_active_level   <= 1'b0;
            emergency_enable     <= 1'b0;
            shut_hold            <= 1'b0;
        end else begin
            if (emergency_enable & (fault_active != fault_prev)) begin
                shutdown_change_flag <= 1'b1;
            end else if (wr_shutdown & wb_dat_i[`PWS_SD_FLAG]) begin
                shutdown_change_flag <= 1'b0;
            end
            if (wr_shutdown) begin
                shutdown_irq_enable <= wb_dat_i[`PWS_SD_IRQ_EN];
                forced_output_level <= wb_dat_i[`PWS_SD_LEVEL];
                fault_active_level  <= wb_dat_i[`PWS_SD_ACT_LVL];
                emergency_enable    <= wb_dat_i[`PWS_SD_ENABLE];
            end
            if (fault_active) begin
                shut_hold <= 1'b1;
            end else if (wr_shutdown & wb_dat_i[`PWS_SD_RESTART] & ~fault_active) begin
                shut_hold <= 1'b0;
            end else if (~emergency_enable) begin
                shut_hold <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            channel_enable      <= `PWS_RESET8;
            clock_select_reg    <= `PWS_RESET8;
            prescale_select_reg <= `PWS_RESET8;
            freeze_clock_gate   <= 1'b0;
            scale_value_a       <= `PWS_RESET8;
            scale_value_b       <= `PWS_RESET8;
        end else if (wr_stb) begin
            if (wb_adr_i == `PWS_ADDR_ENABLE) begin
                channel_enable <= wb_dat_i;
            end else if (wb_adr_i == `PWS_ADDR_CLKSEL) begin
                clock_select_reg <= wb_dat_i;
            end else if (wb_adr_i == `PWS_ADDR_PRESCALE) begin
                prescale_select_reg <= wb_dat_i;
            end else if (wb_adr_i == `PWS_ADDR_CTRL) begin
                freeze_clock_gate <= wb_dat_i[`PWS_CTRL_FREEZE];
            end else if (wb_adr_i == `PWS_ADDR_SCALE_A) begin
                scale_value_a <= wb_dat_i;
            end else if (wb_adr_i == `PWS_ADDR_SCALE_B) begin
                scale_value_b <= wb_dat_i;
            end
        end
    end

    // ****************************************************************
    // Prescaler
    // ****************************************************************
    assign pre_run = ~(freeze_clock_gate & freeze_i)
                   & (|channel_enable);
    assign next_prescale_cnt = prescale_cnt + 7'h01;
    assign clk_a_en = pre_run & prescale_tick(prescale_cnt,
                      prescale_select_reg[`PWS_PRE_A_LSB +: `PWS_PRE_W]);
    assign clk_b_en = pre_run & prescale_tick(prescale_cnt,
                      prescale_select_reg[`PWS_PRE_B_LSB +: `PWS_PRE_W]);

    always @(posedge clk_i) begin
        if (rst_i) begin
            prescale_cnt <= `PWS_ZERO7;
        end else if (pre_run) begin
            prescale_cnt <= next_prescale_cnt;
        end
    end

    // ****************************************************************
    // Scaled clocks
    // ****************************************************************
    assign pulse_a = clk_a_en & (down_a == `PWS_ONE8);
    assign pulse_b = clk_b_en & (down_b == `PWS_ONE8);
    assign sa_en   = pulse_a & div2_a;
    assign sb_en   = pulse_b & div2_b;

    always @(posedge clk_i) begin
        if (rst_i) begin
            down_a <= `PWS_ZERO8;
            down_b <= `PWS_ZERO8;
            div2_a <= 1'b0;
            div2_b <= 1'b0;
        end else begin
            if (wr_scale_a) begin
                down_a <= reload_value(wb_dat_i);
                div2_a <= 1'b0;
            end else if (clk_a_en) begin
                if (down_a == `PWS_ONE8) begin
                    down_a <= reload_value(scale_value_a);
                    div2_a <= ~div2_a;
                end else begin
                    down_a <= down_a - `PWS_ONE8;
                end
            end
            if (wr_scale_b) begin
                down_b <= reload_value(wb_dat_i);
                div2_b <= 1'b0;
            end else if (clk_b_en) begin
                if (down_b == `PWS_ONE8) begin
                    down_b <= reload_value(scale_value_b);
                    div2_b <= ~div2_b;
                end else begin
                    down_b <= down_b - `PWS_ONE8;
                end
            end
        end
    end

    // ****************************************************************
    // Channel clock select
    // ****************************************************************
    always @* begin
        next_clk_en = `PWS_ZERO8;
        for (ch = 0; ch < 8; ch = ch + 1) begin
            if (ch[1]) begin
                next_clk_en[ch] = clock_select_reg[ch] ? sb_en : clk_b_en;
            end else begin
                next_clk_en[ch] = clock_select_reg[ch] ? sa_en : clk_a_en;
            end
            next_clk_en[ch] = next_clk_en[ch] & channel_enable[ch];
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o              <= `PWS_ZERO8;
            wb_ack_o              <= 1'b0;
            irq_o                 <= 1'b0;
            fault_pin_oe_n_o      <= 1'b0;
            channel_enable_o      <= `PWS_ZERO8;
            channel_clk_en_o      <= `PWS_ZERO8;
            force_active_o        <= 1'b0;
            forced_output_level_o <= 1'b0;
        end else begin
            wb_ack_o              <= wr_stb | rd_stb;
            wb_dat_o              <= rd_stb ? next_rd : `PWS_ZERO8;
            irq_o                 <= emergency_enable & shutdown_irq_enable
                                   & shutdown_change_flag;
            fault_pin_oe_n_o      <= emergency_enable;
            channel_enable_o      <= channel_enable;
            channel_clk_en_o      <= next_clk_en;
            forced_output_level_o <= forced_output_level;
            if (fault_active) begin
                force_active_o <= 1'b1;
            end else if (shut_hold & emergency_enable) begin
                force_active_o <= 1'b1;
            end else if (|(counter_zero_i & channel_enable)) begin
                force_active_o <= 1'b0;
            end else if (~shut_hold & ~force_active_o) begin
                force_active_o <= 1'b0;
            end
        end
    end

endmodule // pws_top

//--- testbench/pws_fault_src.sv
// Fault source model driving the channel seven pin
`timescale 1ns/1ps
module pws_fault_src (
    // Clock and control
    input  wire logic       clk_i,
    input  wire logic       act_lvl_i,
    input  wire logic       go_i,
    input  wire logic [3:0] hold_i,
    // Pin
    output logic            pin_o
);
    int left = 0;
    // Active span never shorter than two bus clocks
    always @(posedge clk_i) begin
        if (go_i)
            left <= (hold_i < 2) ? 2 : int'(hold_i);
        else if (left > 0)
            left <= left - 1;
    end
    assign pin_o = (left > 0) ? act_lvl_i : !act_lvl_i;
endmodule // pws_fault_src

//--- testbench/pws_top_sva.sv
// Port assertions for the shutdown and clock-select block
`timescale 1ns/1ps
module pws_top_sva (
    // Bus side
    input wire       clk_i,
    input wire       rst_i,
    input wire       wb_cyc_i,
    input wire       wb_stb_i,
    input wire       wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [7:0] wb_dat_i,
    input wire       wb_sel_i,
    input wire [7:0] wb_dat_o,
    input wire       wb_ack_o,
    // System, pin and channels
    input wire       freeze_i,
    input wire [7:0] counter_zero_i,
    input wire       irq_o,
    input wire       fault_pin_i,
    input wire       fault_pin_oe_n_o,
    input wire [7:0] channel_enable_o,
    input wire [7:0] channel_clk_en_o,
    input wire       force_active_o,
    input wire       forced_output_level_o
);
    logic [7:0] sd;
    logic       frz;
    wire        wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i && !wb_ack_o;
    wire        act = sd[0] && (fault_pin_i == sd[1]);
    wire        cz  = |counter_zero_i;
    // Shadow of written control bits
    always @(posedge clk_i) begin
        if (rst_i) begin
            sd  <= 8'h00;
            frz <= 1'b0;
        end else if (wr && wb_adr_i == 8'h24)
            sd <= wb_dat_i;
        else if (wr && wb_adr_i == 8'h05)
            frz <= wb_dat_i[2];
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_fault_held; act [*3]; endsequence
    sequence s_frozen; (frz && freeze_i) [*3]; endsequence
    sequence s_idle; (channel_enable_o == 8'h00) [*3]; endsequence
    property p_force_on; s_fault_held |-> ##[0:2] force_active_o; endproperty
    property p_irq_gate; irq_o |-> (sd[6] || $past(sd[6])) && (sd[0] || $past(sd[0])); endproperty
    property p_oe_in; sd[0] && $past(sd[0]) |-> fault_pin_oe_n_o; endproperty
    property p_oe_out; !sd[0] && !$past(sd[0]) |-> !fault_pin_oe_n_o; endproperty
    property p_release; $fell(force_active_o) |-> $past(cz) || $past(cz, 2); endproperty
    property p_freeze; s_frozen |-> channel_clk_en_o == 8'h00; endproperty
    property p_idle; s_idle |-> channel_clk_en_o == 8'h00; endproperty
    property p_rd_restart; wb_ack_o && !wb_we_i && wb_adr_i == 8'h24 |-> !wb_dat_o[5]; endproperty
    a_force_on: assert property (p_force_on) else $error("force missing");
    a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");
    a_oe_in: assert property (p_oe_in) else $error("pin not input");
    a_oe_out: assert property (p_oe_out) else $error("pin not driven");
    a_release: assert property (p_release) else $error("early release");
    a_freeze: assert property (p_freeze) else $error("clock not frozen");
    a_idle: assert property (p_idle) else $error("idle clock runs");
    a_rd_restart: assert property (p_rd_restart) else $error("restart reads 1");
endmodule // pws_top_sva
bind pws_top pws_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .freeze_i(freeze_i),
    .counter_zero_i(counter_zero_i), .irq_o(irq_o), .fault_pin_i(fault_pin_i),
    .fault_pin_oe_n_o(fault_pin_oe_n_o), .channel_enable_o(channel_enable_o),
    .channel_clk_en_o(channel_clk_en_o), .force_active_o(force_active_o),
    .forced_output_level_o(forced_output_level_o));

//--- testbench/tb_top.sv
// Self-checking bench for the shutdown and clock-select block
`timescale 1ns/1ps
module tb_top;
    logic       clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sel = 0;
    logic       freeze_i = 0, go = 0, act = 1, al, lvl;
    logic [7:0] adr = 0, dat = 0, counter_zero_i = 0, rd, sd;
    logic [3:0] hold = 4'h8;
    wire  [7:0] dat_o, ch_en, cen;
    wire        ack, irq, pin, oe_n, frc, flvl;
    int         num_errors = 0, check_count = 0, n0, n2, s, e;
    initial forever #20 clk_i = ~clk_i;
    pws_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .freeze_i(freeze_i), .counter_zero_i(counter_zero_i), .irq_o(irq),
        .fault_pin_i(pin), .fault_pin_oe_n_o(oe_n), .channel_enable_o(ch_en),
        .channel_clk_en_o(cen), .force_active_o(frc), .forced_output_level_o(flvl));
    pws_fault_src u_src (.clk_i(clk_i), .act_lvl_i(act), .go_i(go), .hold_i(hold), .pin_o(pin));
    task check(string what, logic [7:0] seen, logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task close_out;
        $display("errors %0d, checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {cyc, stb, sel, we, adr, dat} <= {3'b111, w, a, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task cnt(int len);
        n0 = 0;
        n2 = 0;
        repeat (len) begin
            @(posedge clk_i);
            n0 += cen[0];
            n2 += cen[2];
        end
    endtask
    task fault;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (5) @(posedge clk_i);
    endtask
    task zero_pulse;
        counter_zero_i <= 8'hFF;
        @(posedge clk_i);
        counter_zero_i <= 8'h00;
        repeat (3) @(posedge clk_i);
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        s = $urandom(60973);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, 8'h24, 0); check("shutdown reset", rd, 8'h00);
        bus(0, 8'h30, 0); check("unmapped", rd, 8'h00);
        bus(1, 8'h02, 8'h00); bus(1, 8'h00, 8'hFF);
        for (int n = 0; n < 8; n++) begin
            bus(1, 8'h03, {1'b0, 3'(7 - n), 1'b0, 3'(n)});
            repeat (4) @(posedge clk_i);
            check("enable copy", ch_en, 8'hFF);
            cnt(256);
            e = 256 >> n; check("clock a", 8'(n0 >= e - 1 && n0 <= e + 1), 1);
            e = 256 >> (7 - n); check("clock b", 8'(n2 >= e - 1 && n2 <= e + 1), 1);
        end
        s = $urandom_range(8, 1);
        bus(1, 8'h00, 0); bus(1, 8'h03, 0); bus(1, 8'h02, 8'h05);
        bus(1, 8'h08, 8'(s)); bus(1, 8'h09, 0);
        bus(0, 8'h08, 0); check("scale a value", rd, 8'(s));
        bus(1, 8'h00, 8'hFF);
        cnt(1024);
        e = 512 / s; check("scaled a", 8'(n0 >= e - 1 && n0 <= e + 1), 1);
        check("scaled b", 8'(n2 >= 1 && n2 <= 3), 1);
        bus(1, 8'h05, 8'h04); freeze_i <= 1'b1; repeat (4) @(posedge clk_i);
        cnt(64); check("frozen", 8'(n0 + n2), 0);
        freeze_i <= 1'b0; bus(1, 8'h00, 0); repeat (4) @(posedge clk_i);
        cnt(64); check("idle", 8'(n0 + n2), 0);
        bus(1, 8'h00, 8'hFF);
        for (int k = 0; k < 4; k++) begin
            {al, lvl} = 2'(k);
            sd = {3'b010, lvl, 2'b00, al, 1'b1};
            bus(1, 8'h24, 8'h00);
            act <= al; repeat (4) @(posedge clk_i);
            bus(1, 8'h24, sd | 8'h80); repeat (4) @(posedge clk_i);
            bus(0, 8'h24, 0); check("idle status", rd, sd | {5'h0, !al, 2'b0});
            fault;
            check("force", frc, 1);
            check("level", flvl, lvl);
            check("irq", irq, 1);
            bus(0, 8'h24, 0); check("flag set", rd, sd | {1'b1, 4'h0, al, 2'b0});
            repeat (10) @(posedge clk_i);
            bus(1, 8'h24, sd); bus(0, 8'h24, 0); check("flag kept", rd[7], 1);
            bus(1, 8'h24, sd | 8'hA0); bus(0, 8'h24, 0);
            check("flag clear", rd, sd | {5'h0, !al, 2'b0});
            check("held", frc, 1);
            zero_pulse; check("restarted", frc, 0);
        end
        hold <= 4'($urandom_range(8, 2));
        bus(1, 8'h24, 8'h83); fault; check("masked irq", irq, 0);
        check("pin input", oe_n, 1);
        bus(1, 8'h24, 8'h00); repeat (3) @(posedge clk_i);
        check("pin driven", oe_n, 0);
        check("still forced", frc, 1);
        zero_pulse; check("released", frc, 0);
        close_out;
    end
    initial begin
        #(40 * 20000);
        num_errors++;
        close_out;
    end
endmodule // tb_top
